// ### hw/selfprog_pkg.sv
package selfprog_pkg;
  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int BIT_SPM_EN = 0;
  localparam int BIT_PG_ERASE = 1;
  localparam int BIT_PG_WRITE = 2;
  localparam int BIT_LF_SEL = 3;
  localparam int BIT_RWW_REEN = 4;
  localparam int BIT_SIG_SEL = 5;
  localparam int BIT_RWW_BUSY = 6;
  localparam int BIT_INT_EN = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_FUSE_LO = 4'h1;
  localparam logic [3:0] OFS_FUSE_HI = 4'h2;
  localparam logic [3:0] OFS_FUSE_EXT = 4'h3;
  localparam logic [3:0] OFS_LOCK = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;

  // ----------------------------------------------------------------
  // Lock/fuse and signature addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] Z_FUSE_LO = 16'h0000;
  localparam logic [15:0] Z_LOCK = 16'h0001;
  localparam logic [15:0] Z_FUSE_EXT = 16'h0002;
  localparam logic [15:0] Z_FUSE_HI = 16'h0003;
  localparam logic [15:0] Z_SIG_ID0 = 16'h0000;
  localparam logic [15:0] Z_SIG_CAL = 16'h0001;
  localparam logic [15:0] Z_SIG_ID1 = 16'h0002;
  localparam logic [15:0] Z_SIG_ID2 = 16'h0004;
  localparam logic [7:0] RESERVED_BYTE = 8'hff;
  localparam logic [7:0] FUSE_RESET = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LOAD_WINDOW = 3;
  localparam int STORE_WINDOW = 4;
  localparam int CLK_MHZ = 250;
  localparam int PROG_MIN_US = 3700;
  localparam int PROG_MAX_US = 4500;
  localparam int PROG_MIN_CYC = PROG_MIN_US * CLK_MHZ;
  localparam int PROG_MAX_CYC = PROG_MAX_US * CLK_MHZ;
  localparam int PROG_CYC = (PROG_MIN_CYC + PROG_MAX_CYC) / 2;
endpackage

// ### hw/op_timer.sv
module op_timer
  import selfprog_pkg::*;
#(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic [W-1:0] length,
  // Status
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    if (start && cnt_ff == '0) begin
      nxt_cnt = length;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
      nxt_done = (cnt_ff == W'(1));
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;
endmodule

// ### hw/selfprog_ctrl.sv
// Decided for this implementation: the plain strobed port and the register offsets.
module selfprog_ctrl
  import selfprog_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter logic [7:0] SIG_ID0 = 8'h11,
  parameter logic [7:0] SIG_ID1 = 8'h22,
  parameter logic [7:0] SIG_ID2 = 8'h33,
  parameter logic [71:0] SERIAL = 72'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core instruction port
  input wire logic load_req,
  input wire logic store_req,
  input wire logic [15:0] z_ptr,
  input wire logic [7:0] flash_byte,
  output logic [7:0] load_data,
  output logic load_special,
  // Status from elsewhere
  input wire logic eeprom_write_busy,
  input wire logic [7:0] rc_cal,
  // Flash array side
  output logic erase_pulse,
  output logic write_pulse,
  output logic lock_write_pulse,
  output logic buffer_flush,
  output logic app_read_block,
  output logic [7:0] lock_bits
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [2:0] win_ff, nxt_win;
  logic [7:0] fuse_lo_ff, nxt_fuse_lo;
  logic [7:0] fuse_hi_ff, nxt_fuse_hi;
  logic [7:0] fuse_ext_ff, nxt_fuse_ext;
  logic [7:0] lock_ff, nxt_lock;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [7:0] ldata_ff, nxt_ldata;
  logic lspec_ff, nxt_lspec;
  logic ee_s1_ff, ee_s2_ff;
  logic er_ff, wr_ff, lw_ff, fl_ff, blk_ff;
  logic nxt_er, nxt_wr, nxt_lw, nxt_fl, nxt_blk;
  logic [7:0] pend_lock_ff, nxt_pend_lock;
  logic pend_lw_ff, nxt_pend_lw;
  logic t_start, t_busy, t_done;
  logic [7:0] special_byte;
  logic [7:0] sig_byte;
  logic rw_refused;
  logic pend_on;

  // ----------------------------------------------------------------
  // Programming timer
  // ----------------------------------------------------------------
  op_timer #(.W(24)) u_timer (
    .clock(clock),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .start(t_start),
    .length(24'(PROG_CYCLES)),
    .busy(t_busy),
    .done(t_done)
  );

  // ----------------------------------------------------------------
  // EEPROM busy synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ee_s1_ff <= 1'b0;
      ee_s2_ff <= 1'b0;
    end else if (clk_en) begin
      ee_s1_ff <= eeprom_write_busy;
      ee_s2_ff <= ee_s1_ff;
    end
  end
  assign rw_refused = ee_s2_ff;

  // ----------------------------------------------------------------
  // Signature row
  // ----------------------------------------------------------------
  always_comb begin
    case (z_ptr)
      Z_SIG_ID0: sig_byte = SIG_ID0;
      Z_SIG_CAL: sig_byte = rc_cal;
      Z_SIG_ID1: sig_byte = SIG_ID1;
      Z_SIG_ID2: sig_byte = SIG_ID2;
      16'h000e: sig_byte = SERIAL[15:8];
      16'h000f: sig_byte = SERIAL[7:0];
      16'h0010: sig_byte = SERIAL[31:24];
      16'h0011: sig_byte = SERIAL[23:16];
      16'h0012: sig_byte = SERIAL[47:40];
      16'h0013: sig_byte = SERIAL[39:32];
      16'h0015: sig_byte = SERIAL[55:48];
      16'h0016: sig_byte = SERIAL[63:56];
      16'h0017: sig_byte = SERIAL[71:64];
      default: sig_byte = RESERVED_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Lock and fuse selection
  // ----------------------------------------------------------------
  always_comb begin
    case (z_ptr)
      Z_FUSE_LO: special_byte = fuse_lo_ff;
      Z_LOCK: special_byte = {2'b11, lock_ff[5:0]};
      Z_FUSE_EXT: special_byte = fuse_ext_ff;
      Z_FUSE_HI: special_byte = fuse_hi_ff;
      default: special_byte = RESERVED_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Control register and timed sequence
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_win = win_ff;
    nxt_fuse_lo = fuse_lo_ff;
    nxt_fuse_hi = fuse_hi_ff;
    nxt_fuse_ext = fuse_ext_ff;
    nxt_lock = lock_ff;
    nxt_ldata = flash_byte;
    nxt_lspec = 1'b0;
    nxt_er = 1'b0;
    nxt_wr = 1'b0;
    nxt_lw = 1'b0;
    nxt_fl = 1'b0;
    nxt_blk = blk_ff;
    nxt_pend_lock = pend_lock_ff;
    nxt_pend_lw = pend_lw_ff;
    t_start = 1'b0;
    nxt_rdata = 8'h00;
    pend_on = 1'b0;
    if (pend_lw_ff) begin
      pend_on = 1'b1;
    end
    if (pend_on && !t_busy && !t_done && !rw_refused) begin
      t_start = 1'b1;
    end
    if (win_ff != 3'd0) begin
      nxt_win = win_ff - 3'd1;
    end
    if (t_done) begin
      nxt_ctrl[BIT_SPM_EN] = 1'b0;
      nxt_ctrl[BIT_PG_ERASE] = 1'b0;
      nxt_ctrl[BIT_PG_WRITE] = 1'b0;
      nxt_ctrl[BIT_LF_SEL] = 1'b0;
      nxt_blk = 1'b0;
      if (pend_lw_ff) begin
        nxt_lock = pend_lock_ff;
        nxt_pend_lw = 1'b0;
      end
    end else if (!t_busy && ctrl_ff[BIT_SPM_EN] && win_ff == 3'd1) begin
      nxt_ctrl[5:0] = 6'h00;
    end
    if (ctrl_ff[BIT_SPM_EN] && win_ff > 3'd1 && !t_busy) begin
      if (load_req && (ctrl_ff[BIT_SIG_SEL] || (ctrl_ff[BIT_LF_SEL] &&
          !rw_refused && win_ff > 3'(STORE_WINDOW - LOAD_WINDOW + 1)))) begin
        nxt_lspec = 1'b1;
        nxt_ldata = ctrl_ff[BIT_SIG_SEL] ? sig_byte : special_byte;
        nxt_ctrl[5:0] = 6'h00;
        nxt_win = 3'd0;
      end else if (store_req && !rw_refused && !ctrl_ff[BIT_SIG_SEL]) begin
        nxt_win = 3'd0;
        if (ctrl_ff[BIT_PG_ERASE] || ctrl_ff[BIT_PG_WRITE]) begin
          t_start = 1'b1;
          nxt_er = ctrl_ff[BIT_PG_ERASE];
          nxt_wr = ctrl_ff[BIT_PG_WRITE];
          nxt_blk = 1'b1;
          nxt_ctrl[BIT_RWW_BUSY] = 1'b1;
        end else if (ctrl_ff[BIT_LF_SEL]) begin
          t_start = 1'b1;
          nxt_lw = 1'b1;
          nxt_pend_lw = 1'b1;
          nxt_pend_lock = lock_ff & {2'b11, reg_wdata[5:0] | 6'h00};
        end else if (ctrl_ff[BIT_RWW_REEN]) begin
          nxt_fl = 1'b1;
          nxt_ctrl[BIT_RWW_BUSY] = 1'b0;
          nxt_ctrl[5:0] = 6'h00;
        end else begin
          nxt_ctrl[BIT_RWW_BUSY] = 1'b0;
          nxt_ctrl[5:0] = 6'h00;
        end
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          nxt_ctrl[BIT_INT_EN] = reg_wdata[BIT_INT_EN];
          if (!t_busy && !rw_refused && !pend_on) begin
            nxt_ctrl[5:0] = reg_wdata[5:0];
            nxt_win = reg_wdata[BIT_SIG_SEL] ?
                      3'(LOAD_WINDOW + 1) : 3'(STORE_WINDOW + 1);
          end
        end
        OFS_FUSE_LO: nxt_fuse_lo = reg_wdata;
        OFS_FUSE_HI: nxt_fuse_hi = reg_wdata;
        OFS_FUSE_EXT: nxt_fuse_ext = reg_wdata;
        default: nxt_rdata = 8'h00;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: nxt_rdata = ctrl_ff;
        OFS_FUSE_LO: nxt_rdata = fuse_lo_ff;
        OFS_FUSE_HI: nxt_rdata = fuse_hi_ff;
        OFS_FUSE_EXT: nxt_rdata = fuse_ext_ff;
        OFS_LOCK: nxt_rdata = lock_ff;
        OFS_STATUS: nxt_rdata = {6'h00, rw_refused, t_busy | pend_on};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Pending lock-write state lives on a reset that does not abort it
  always_ff @(posedge clock) begin
    if (clk_en) begin
      pend_lock_ff <= nxt_pend_lock;
      pend_lw_ff <= nxt_pend_lw;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= CTRL_RESET;
      win_ff <= 3'd0;
      fuse_lo_ff <= FUSE_RESET;
      fuse_hi_ff <= FUSE_RESET;
      fuse_ext_ff <= FUSE_RESET;
      lock_ff <= FUSE_RESET;
      rdata_ff <= 8'h00;
      ldata_ff <= 8'h00;
      lspec_ff <= 1'b0;
      er_ff <= 1'b0;
      wr_ff <= 1'b0;
      lw_ff <= 1'b0;
      fl_ff <= 1'b0;
      blk_ff <= 1'b0;
    end else if (clk_en) begin
      ctrl_ff <= nxt_ctrl;
      win_ff <= nxt_win;
      fuse_lo_ff <= nxt_fuse_lo;
      fuse_hi_ff <= nxt_fuse_hi;
      fuse_ext_ff <= nxt_fuse_ext;
      lock_ff <= nxt_lock;
      rdata_ff <= nxt_rdata;
      ldata_ff <= nxt_ldata;
      lspec_ff <= nxt_lspec;
      er_ff <= nxt_er;
      wr_ff <= nxt_wr;
      lw_ff <= nxt_lw;
      fl_ff <= nxt_fl;
      blk_ff <= nxt_blk;
    end
  end

  assign reg_rdata = rdata_ff;
  assign load_data = ldata_ff;
  assign load_special = lspec_ff;
  assign erase_pulse = er_ff;
  assign write_pulse = wr_ff;
  assign lock_write_pulse = lw_ff;
  assign buffer_flush = fl_ff;
  assign app_read_block = blk_ff;
  assign lock_bits = lock_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_refuse_prog: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && rw_refused && !t_busy |=> !t_busy)
    else $error("Programming started during EEPROM write");
  a_refuse_read: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && rw_refused && reg_wr && reg_addr == OFS_CTRL && !t_busy
    |=> ctrl_ff[5:0] == $past(ctrl_ff[5:0]) || !ctrl_ff[BIT_SPM_EN])
    else $error("Command accepted during EEPROM write");
  a_window_clear: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && win_ff == 3'd1 && !t_busy && !reg_wr && !t_done
    |=> ctrl_ff[BIT_SPM_EN] == 1'b0)
    else $error("Enable bit outlived its window");
  a_lock_layout: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && lspec_ff && $past(z_ptr) == Z_LOCK && $past(ctrl_ff[3])
    |-> load_data[7:6] == 2'b11)
    else $error("Lock byte upper bits wrong");
  a_one_load: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && lspec_ff |=> !lspec_ff)
    else $error("Special read lasted more than one load");
  a_block_busy: assert property (@(posedge clock) disable iff (!arst_n)
    erase_pulse || write_pulse |-> app_read_block)
    else $error("Application area readable during programming");
  a_flush_clear: assert property (@(posedge clock) disable iff (!arst_n)
    buffer_flush |-> !ctrl_ff[BIT_RWW_BUSY])
    else $error("Flush left busy flag set");
  a_sig_cal: assert property (@(posedge clock) disable iff (!arst_n)
    clk_en && nxt_lspec && ctrl_ff[BIT_SIG_SEL] && z_ptr == Z_SIG_CAL
    |=> load_data == $past(rc_cal))
    else $error("Calibration byte not returned");
endmodule

// ### dv/cpu_model.sv
module cpu_model
  import selfprog_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register port
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Instruction port
  output logic load_req,
  output logic store_req,
  output logic [15:0] z_ptr,
  input wire logic [7:0] load_data,
  input wire logic load_special,
  // Flash array side
  input wire logic erase_pulse,
  input wire logic write_pulse,
  input wire logic lock_write_pulse,
  input wire logic buffer_flush,
  input wire logic app_read_block
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rd_q, ld_q;
  logic sp_q, blk_q;
  int n_er, n_wp, n_lw, n_fl;
  logic poll_fail = 1'b0;

  initial begin
    {reg_wr, reg_rd, load_req, store_req} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    z_ptr = 16'h0000;
  end

  // --------------------------------
  // Pulse counters
  // --------------------------------
  always @(posedge clock) begin
    n_er += erase_pulse;
    n_wp += write_pulse;
    n_lw += lock_write_pulse;
    n_fl += buffer_flush;
  end

  // --------------------------------
  // Instruction cycles
  // --------------------------------
  // Unused address, data and Z lines carry the inverse of their last value; unused strobes are driven low
  task automatic cyc(input logic [3:0] s, input logic [3:0] a,
      input logic [7:0] d, input logic [15:0] z);
    {reg_wr, reg_rd, load_req, store_req} <= s;
    reg_addr <= a;
    reg_wdata <= d;
    z_ptr <= z;
    @(posedge clock);
    #1;
    rd_q = reg_rdata;
    ld_q = load_data;
    sp_q = load_special;
    blk_q = app_read_block;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cyc(4'h8, a, d, ~z_ptr);
  endtask
  task automatic rd(input logic [3:0] a);
    cyc(4'h4, a, ~reg_wdata, ~z_ptr);
  endtask
  task automatic lpm(input logic [15:0] z);
    cyc(4'h2, ~reg_addr, ~reg_wdata, z);
  endtask
  // Never preceded by a page fill, so a flush loses nothing
  task automatic spm(input logic [7:0] d);
    cyc(4'h1, ~reg_addr, d, ~z_ptr);
  endtask
  task automatic idle();
    cyc(4'h0, ~reg_addr, ~reg_wdata, ~z_ptr);
  endtask
  task automatic ctrl(input logic [7:0] v, input logic poll);
    int i;
    for (i = 0; poll && i < 16; i++) begin
      rd(OFS_STATUS);
      if (rd_q[1] === 1'b0) break;
    end
    if (poll && i == 16) poll_fail = 1'b1;
    wr(OFS_CTRL, v);
  endtask
endmodule

// ### dv/tb.sv
module tb
  import selfprog_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC = 20;
  logic clock, arst_n, ebusy;
  logic ce;
  logic [7:0] cal;
  logic [3:0] ra;
  logic [7:0] wd, rq, ld, lb;
  logic [15:0] z;
  logic wr, rd, lq, sq, ls, er, wp, lw, fl, blk;
  int errors, n_compared;

  selfprog_ctrl #(.PROG_CYCLES(PC), .SERIAL(72'h989796959493929190)) DUT (
    .clock(clock), .arst_n(arst_n), .clk_en(ce),
    .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rq), .load_req(lq), .store_req(sq), .z_ptr(z),
    .flash_byte(z[7:0] ^ 8'h5a), .load_data(ld), .load_special(ls),
    .eeprom_write_busy(ebusy), .rc_cal(cal), .erase_pulse(er),
    .write_pulse(wp), .lock_write_pulse(lw), .buffer_flush(fl),
    .app_read_block(blk), .lock_bits(lb));
  cpu_model cpu (
    .clock(clock), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rq), .load_req(lq), .store_req(sq),
    .z_ptr(z), .load_data(ld), .load_special(ls), .erase_pulse(er),
    .write_pulse(wp), .lock_write_pulse(lw), .buffer_flush(fl),
    .app_read_block(blk));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (cpu.poll_fail) begin
      errors++;
      $display("Error at %0t: status poll limit reached", $time);
      end_sim();
    end
  end

  // --------------------------------
  // Checking and closing
  // --------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic done(output int i);
    for (i = 0; i < 400; i++) begin
      cpu.rd(OFS_STATUS);
      if (cpu.rd_q[0] === 1'b0) break;
    end
    if (i == 400) begin
      errors++;
      $display("Error at %0t: timer stuck busy", $time);
      end_sim();
    end
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_regs();
    cpu.rd(OFS_CTRL);
    chk(cpu.rd_q, CTRL_RESET);
    for (int a = 1; a < 5; a++) begin
      cpu.rd(4'(a));
      chk(cpu.rd_q, FUSE_RESET);
    end
    ce <= 1'b0;
    cpu.wr(OFS_FUSE_LO, 8'h00);
    ce <= 1'b1;
    cpu.rd(OFS_FUSE_LO);
    chk(cpu.rd_q, FUSE_RESET);
    cpu.wr(4'hf, 8'hff);
    cpu.rd(OFS_CTRL);
    chk(cpu.rd_q, CTRL_RESET);
  endtask
  task automatic t_fuse();
    logic [15:0] zs[3] = '{Z_FUSE_LO, Z_FUSE_HI, Z_FUSE_EXT};
    logic [7:0] vs[3] = '{8'ha5, 8'h3c, 8'hf6};
    for (int k = 0; k < 3; k++) cpu.wr(4'(k + 1), vs[k]);
    for (int k = 0; k < 3; k++) begin
      cpu.ctrl(8'h09, 1'b1);
      cpu.lpm(zs[k]);
      chk(cpu.ld_q, vs[k]);
      chk({7'h0, cpu.sp_q}, 8'h01);
      cpu.rd(OFS_CTRL);
      chk({2'b00, cpu.rd_q[5:0]}, 8'h00);
      cpu.lpm(zs[k]);
      chk(cpu.ld_q, zs[k][7:0] ^ 8'h5a);
    end
  endtask
  task automatic t_lock();
    cpu.ctrl(8'h09, 1'b0);
    repeat (4) cpu.idle();
    cpu.lpm(Z_LOCK);
    chk(cpu.ld_q, Z_LOCK[7:0] ^ 8'h5a);
    chk({7'h0, cpu.sp_q}, 8'h00);
    cpu.ctrl(8'h09, 1'b0);
    cpu.lpm(Z_LOCK);
    chk(cpu.ld_q, 8'hff);
  endtask
  task automatic t_sig();
    logic [7:0] zs[15] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h0e, 8'h0f,
      8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h14, 8'h03};
    logic [7:0] vs[15] = '{8'h11, 8'hc6, 8'h22, 8'h33, 8'h91, 8'h90,
      8'h93, 8'h92, 8'h95, 8'h94, 8'h96, 8'h97, 8'h98, 8'hff, 8'hff};
    for (int k = 0; k < 15; k++) begin
      cpu.ctrl(8'h21, 1'b0);
      cpu.lpm({8'h00, zs[k]});
      chk(cpu.ld_q, vs[k]);
      chk({7'h0, cpu.sp_q}, 8'h01);
    end
  endtask
  task automatic t_ee();
    int n;
    ebusy <= 1'b1;
    repeat (3) cpu.idle();
    cpu.rd(OFS_STATUS);
    chk({7'h0, cpu.rd_q[1]}, 8'h01);
    cpu.ctrl(8'h09, 1'b0);
    cpu.lpm(Z_FUSE_LO);
    chk({7'h0, cpu.sp_q}, 8'h00);
    n = cpu.n_er;
    cpu.ctrl(8'h03, 1'b0);
    cpu.spm(8'hff);
    repeat (2) cpu.idle();
    chk(8'(cpu.n_er - n), 8'h00);
    ebusy <= 1'b0;
    repeat (3) cpu.idle();
  endtask
  task automatic t_ops();
    logic [7:0] cmd[3] = '{8'h03, 8'h05, 8'h11};
    int e, w, f, n;
    for (int k = 0; k < 3; k++) begin
      e = cpu.n_er;
      w = cpu.n_wp;
      f = cpu.n_fl;
      cpu.ctrl(cmd[k], 1'b1);
      cpu.spm(8'hff);
      repeat (2) cpu.idle();
      chk(8'(cpu.n_er - e), 8'(k == 0));
      chk(8'(cpu.n_wp - w), 8'(k == 1));
      chk(8'(cpu.n_fl - f), 8'(k == 2));
      chk({7'h0, cpu.blk_q}, 8'(k < 2));
      done(n);
      if (k < 2) chk(8'(n >= PC - 6 && n <= PC + 1), 8'h01);
      chk({7'h0, cpu.blk_q}, 8'h00);
      cpu.rd(OFS_CTRL);
      chk({7'h0, cpu.rd_q[BIT_RWW_BUSY]}, 8'(k < 2));
    end
    e = cpu.n_er;
    cpu.ctrl(8'h03, 1'b1);
    repeat (4) cpu.idle();
    cpu.spm(8'hff);
    repeat (2) cpu.idle();
    chk(8'(cpu.n_er - e), 8'h00);
  endtask
  task automatic t_rst();
    int l, n;
    l = cpu.n_lw;
    cpu.ctrl(8'h09, 1'b1);
    cpu.spm(8'hf0);
    repeat (2) cpu.idle();
    chk(8'(cpu.n_lw - l), 8'h01);
    chk({7'h0, cpu.blk_q}, 8'h00);
    arst_n <= 1'b0;
    repeat (2) cpu.idle();
    arst_n <= 1'b1;
    done(n);
    chk(8'(n >= PC - 8), 8'h01);
    chk({2'b00, lb[5:0]}, 8'h30);
    cpu.ctrl(8'h09, 1'b1);
    cpu.lpm(Z_LOCK);
    chk(cpu.ld_q, 8'hf0);
  endtask

  initial begin
    #100000;
    errors++;
    $display("Error at %0t: run too long", $time);
    end_sim();
  end
  initial begin
    errors = 0;
    n_compared = 0;
    arst_n = 1'b0;
    ebusy = 1'b0;
    ce = 1'b1;
    cal = 8'hc6;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_fuse();
    t_lock();
    t_sig();
    t_ee();
    t_ops();
    t_rst();
    end_sim();
  end
endmodule
